/* File: timer_b_map.svh */
`ifndef TIMER_B_MAP_SVH
`define TIMER_B_MAP_SVH

// Register indexes; the byte address is four times the index
`define IDX_IRQ_CONTROL      12'h00b
`define IDX_IRQ_FLAG         12'h00c
`define IDX_COUNT_LOW        12'h00e
`define IDX_COUNT_HIGH       12'h00f
`define IDX_TIMER_CONTROL    12'h010
`define IDX_IRQ_ENABLE       12'h08c

// Control register field positions
`define CTL_RUN_ENABLE       0
`define CTL_CLOCK_SOURCE     1
`define CTL_SYNC_BYPASS      2
`define CTL_LP_OSC_ENABLE    3
`define CTL_PRESCALE_LO      4
`define CTL_PRESCALE_HI      5
`define CTL_GATE_ENABLE      6

// Interrupt register field positions
`define FLAG_OVERFLOW        0
`define IEN_OVERFLOW         0
`define ICTL_PERIPHERAL      6
`define ICTL_GLOBAL          7

// Reset values
`define RST_CONTROL          7'h00
`define RST_COUNT            16'h0000
`define RST_IRQ_CONTROL      2'h0

// Timing: system clock cycles per instruction cycle (Fosc/4)
`define INSTR_CYCLE_CLOCKS   4

`endif

/* File: timer_b_pkg.sv */
package timer_b_pkg;

   typedef enum logic [1:0] {
      MODE_TIMER         = 2'b00,
      MODE_SYNC_COUNTER  = 2'b01,
      MODE_ASYNC_COUNTER = 2'b10
   } count_mode_t;

endpackage : timer_b_pkg

/* File: pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // Raw pins
   input  wire logic [WIDTH-1:0] pin,
   // Synchronised level and edges
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] prev;

   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("pin_sync needs WIDTH of at least 1");
      end
   endgenerate

   // The first stage feeds only the second
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta  <= '0;
         level <= '0;
         prev  <= '0;
      end else begin
         meta  <= pin;
         level <= meta;
         prev  <= level;
      end
   end

   assign rise = level & ~prev;
   assign fall = ~level & prev;

endmodule : pin_sync

/* File: gated_sixteen_bit_timer.sv */
// What this block does
// - Sixteen-bit count in a high and a low byte, both read and written by software.
// - Three modes: prescaled timer, synchronous counter, asynchronous counter.
// - Timer mode advances once per instruction cycle ahead of the prescaler.
// - Counter mode advances on rising edges of the external count input, or of the oscillator pin when the low-power oscillator is selected.
// - A falling edge must be seen before the first rising edge counts.
// - Both timer and counter clocks can be gated by the active-low gate input.
// - Gate enable ignored while stopped; when set, count only while gate pin low.
// - Rollover from all ones to zero sets the overflow flag, bit 0.
// - Interrupt only when overflow enable, peripheral enable and global enable all set.
// - Prescale select 00,01,10,11 divides the input by 1,2,4,8.
// - Prescale counter hidden from software and cleared by any count byte write.
// - Low-power oscillator enable only acts with internal oscillator, no clock out.
// - With external source, bypass 1 leaves input unsynchronised, 0 synchronises it.
// - Source select 1 picks external pin rising edges, 0 picks Fosc/4.
// - Unsynchronised counter keeps counting in sleep and its overflow can wake.
`timescale 1ns/1ps
`include "timer_b_map.svh"

module gated_sixteen_bit_timer #(
   parameter int INSTR_DIV = `INSTR_CYCLE_CLOCKS
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Pins
   input  wire logic        external_count_input,
   input  wire logic        oscillator_out_pin,
   input  wire logic        gate_input_n,
   // System state
   input  wire logic        internal_oscillator,
   input  wire logic        sleep_mode,
   // Status outputs
   output logic             low_power_osc_on,
   output logic             wake_request,
   output logic             irq
);

   localparam int DIV_W = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;

   generate
      if (INSTR_DIV < 1) begin : g_bad_div
         $error("INSTR_DIV must be at least 1");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [6:0]  control;
   logic [15:0] count;
   logic        overflow_flag;
   logic        overflow_irq_enable;
   logic        peripheral_irq_global_enable;
   logic        global_irq_enable;

   logic        run_enable;
   logic        clock_source_select;
   logic        sync_bypass;
   logic        low_power_osc_enable;
   logic [1:0]  prescale_select;
   logic        gate_enable;

   assign run_enable           = control[`CTL_RUN_ENABLE];
   assign clock_source_select  = control[`CTL_CLOCK_SOURCE];
   assign sync_bypass          = control[`CTL_SYNC_BYPASS];
   assign low_power_osc_enable = control[`CTL_LP_OSC_ENABLE];
   assign prescale_select      = control[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO];
   assign gate_enable          = control[`CTL_GATE_ENABLE];

   ////////////////////////////////////////////////////////////////////////////
   // APB decode

   logic [11:0] reg_index;
   logic        aligned;
   logic        setup;
   logic        access;
   logic        wr;
   logic        rd;
   logic        hit_ictl;
   logic        hit_flag;
   logic        hit_low;
   logic        hit_high;
   logic        hit_ctl;
   logic        hit_ien;
   logic        mapped;

   assign reg_index = {2'h0, paddr[11:2]};
   assign aligned   = (paddr[1:0] == 2'h0);
   assign hit_ictl  = aligned && (reg_index == `IDX_IRQ_CONTROL);
   assign hit_flag  = aligned && (reg_index == `IDX_IRQ_FLAG);
   assign hit_low   = aligned && (reg_index == `IDX_COUNT_LOW);
   assign hit_high  = aligned && (reg_index == `IDX_COUNT_HIGH);
   assign hit_ctl   = aligned && (reg_index == `IDX_TIMER_CONTROL);
   assign hit_ien   = aligned && (reg_index == `IDX_IRQ_ENABLE);
   assign mapped    = hit_ictl | hit_flag | hit_low | hit_high | hit_ctl | hit_ien;

   assign setup   = psel && !penable;
   assign access  = psel && penable;
   assign wr      = access && pwrite && mapped;
   assign rd      = access && !pwrite && mapped;
   assign pready  = 1'b1;
   assign pslverr = access && !mapped;

   // Read data is taken in the setup cycle so it is a flop at the access edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h00000000;
      end else if (setup) begin
         prdata <= 32'h00000000;
         if (hit_low) begin
            prdata[7:0] <= count[7:0];
         end
         if (hit_high) begin
            prdata[7:0] <= count[15:8];
         end
         if (hit_ctl) begin
            prdata[7:0] <= {1'b0, control};
         end
         if (hit_flag) begin
            prdata[`FLAG_OVERFLOW] <= overflow_flag;
         end
         if (hit_ien) begin
            prdata[`IEN_OVERFLOW] <= overflow_irq_enable;
         end
         if (hit_ictl) begin
            prdata[`ICTL_GLOBAL]     <= global_irq_enable;
            prdata[`ICTL_PERIPHERAL] <= peripheral_irq_global_enable;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         control <= `RST_CONTROL;
      end else if (wr && hit_ctl) begin
         control <= pwdata[6:0];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         overflow_irq_enable          <= 1'b0;
         {global_irq_enable, peripheral_irq_global_enable} <= `RST_IRQ_CONTROL;
      end else begin
         if (wr && hit_ien) begin
            overflow_irq_enable <= pwdata[`IEN_OVERFLOW];
         end
         if (wr && hit_ictl) begin
            global_irq_enable            <= pwdata[`ICTL_GLOBAL];
            peripheral_irq_global_enable <= pwdata[`ICTL_PERIPHERAL];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: count pin, oscillator pin, gate pin

   logic [2:0] pin_level;
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;

   pin_sync #(
      .WIDTH (3)
   ) u_pin_sync (
      .clk   (clk),
      .nrst  (nrst),
      .pin   ({gate_input_n, oscillator_out_pin, external_count_input}),
      .level (pin_level),
      .rise  (pin_rise),
      .fall  (pin_fall)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Instruction cycle enable

   logic [DIV_W-1:0] div_count;
   logic             instr_tick;

   assign instr_tick = (div_count == DIV_W'(INSTR_DIV - 1));

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_count <= '0;
      end else if (instr_tick) begin
         div_count <= '0;
      end else begin
         div_count <= div_count + DIV_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Source and mode selection

   timer_b_pkg::count_mode_t mode;
   logic                     lp_select;
   logic                     src_rise;
   logic                     src_fall;

   // Oscillator only honoured with the internal oscillator, no clock out
   assign lp_select        = low_power_osc_enable && internal_oscillator;
   assign low_power_osc_on = lp_select;
   assign src_rise         = lp_select ? pin_rise[1] : pin_rise[0];
   assign src_fall         = lp_select ? pin_fall[1] : pin_fall[0];

   always_comb begin
      if (!clock_source_select) begin
         mode = timer_b_pkg::MODE_TIMER;
      end else if (sync_bypass) begin
         mode = timer_b_pkg::MODE_ASYNC_COUNTER;
      end else begin
         mode = timer_b_pkg::MODE_SYNC_COUNTER;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Falling-edge arming and synchronous edge holding

   logic armed;
   logic pending_edge;
   logic counted_rise;

   assign counted_rise = src_rise && armed;

   // Disarmed whenever the internal clock is selected, so a switch from timer mode to a counter mode waits for a new falling edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         armed <= 1'b0;
      end else if (!clock_source_select) begin
         armed <= 1'b0;
      end else if (src_fall) begin
         armed <= 1'b1;
      end
   end

   // Synchronous mode aligns each pin edge to the next instruction cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pending_edge <= 1'b0;
      end else if (mode != timer_b_pkg::MODE_SYNC_COUNTER) begin
         pending_edge <= 1'b0;
      end else if (counted_rise) begin
         pending_edge <= 1'b1;
      end else if (instr_tick) begin
         pending_edge <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input event, gating and prescaler

   logic       input_event;
   logic       counting_on;
   logic       awake_ok;
   logic       step;
   logic [2:0] presc;
   logic [2:0] presc_limit;
   logic       inc;
   logic       count_write;

   always_comb begin
      unique case (mode)
         timer_b_pkg::MODE_TIMER:         input_event = instr_tick;
         timer_b_pkg::MODE_SYNC_COUNTER:  input_event = instr_tick && pending_edge;
         timer_b_pkg::MODE_ASYNC_COUNTER: input_event = counted_rise;
         default:                         input_event = 1'b0;
      endcase
   end

   // Gate level only matters while running with gating on
   assign counting_on = run_enable && (!gate_enable || !pin_level[2]);
   // Only the unsynchronised counter runs in sleep
   assign awake_ok    = !sleep_mode || (mode == timer_b_pkg::MODE_ASYNC_COUNTER);
   assign step        = input_event && counting_on && awake_ok;
   assign presc_limit = 3'((4'h1 << prescale_select) - 4'h1);
   assign inc         = step && (presc == presc_limit);
   assign count_write = wr && (hit_low || hit_high);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         presc <= 3'h0;
      end else if (count_write) begin
         presc <= 3'h0;
      end else if (inc) begin
         presc <= 3'h0;
      end else if (step) begin
         presc <= presc + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Count

   // A byte write wins over an increment in the same cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count <= `RST_COUNT;
      end else if (wr && hit_low) begin
         count <= {count[15:8], pwdata[7:0]};
      end else if (wr && hit_high) begin
         count <= {pwdata[7:0], count[7:0]};
      end else if (inc) begin
         count <= count + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Overflow flag and interrupt

   logic overflow_set;
   logic overflow_clear;

   assign overflow_set   = inc && (count == 16'hffff);
   // Cleared by a read of the flag register or by writing the bit to zero
   assign overflow_clear = (rd && hit_flag) || (wr && hit_flag && !pwdata[`FLAG_OVERFLOW]);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         overflow_flag <= 1'b0;
      end else if (overflow_set) begin
         overflow_flag <= 1'b1;
      end else if (overflow_clear) begin
         overflow_flag <= 1'b0;
      end
   end

   // Wake needs no global enable; the vector needs it too
   assign wake_request = overflow_flag && overflow_irq_enable
                         && peripheral_irq_global_enable;
   assign irq          = wake_request && global_irq_enable;

endmodule : gated_sixteen_bit_timer

/* File: timer_b_properties.sv */
`timescale 1ns/1ps
module timer_b_properties (
   // Clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Status
   input wire logic        internal_oscillator,
   input wire logic        low_power_osc_on,
   input wire logic        wake_request,
   input wire logic        irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic acc;
   logic mapped;
   assign acc = psel && penable;
   assign mapped = paddr inside {12'h02c, 12'h030, 12'h038, 12'h03c, 12'h040, 12'h230};
   ////////////////////////////////////////////////////////////////////////////
   a_no_wait:
      assert property (psel |-> pready) else $error("pready low");
   a_bad_addr:
      assert property (acc && !mapped |-> pslverr && prdata == 32'h0) else $error("not refused");
   a_good_addr:
      assert property (acc && mapped |-> !pslverr) else $error("mapped access refused");
   a_err_phase:
      assert property (pslverr |-> acc) else $error("pslverr outside access");
   a_read_hold:
      assert property (acc |=> $stable(prdata)) else $error("read data moved");
   a_irq_cause:
      assert property (irq |-> wake_request) else $error("irq without enabled flag");
   a_flag_sticky:
      assert property (wake_request && !acc |=> wake_request) else $error("flag lost");
   a_osc_gate:
      assert property (low_power_osc_on |-> internal_oscillator) else $error("osc on wrongly");
   a_top_zero:
      assert property (acc && paddr == 12'h040 |-> prdata[31:7] == 25'h0) else $error("bit7 set");
   c_irq: cover property ($rose(irq));
   c_err: cover property (pslverr);
   c_osc: cover property (low_power_osc_on);
   c_wake: cover property (wake_request && !irq);
endmodule : timer_b_properties

bind gated_sixteen_bit_timer timer_b_properties u_props (
   .clk                 (clk),
   .nrst                (nrst),
   .psel                (psel),
   .penable             (penable),
   .paddr               (paddr),
   .prdata              (prdata),
   .pready              (pready),
   .pslverr             (pslverr),
   .internal_oscillator (internal_oscillator),
   .low_power_osc_on    (low_power_osc_on),
   .wake_request        (wake_request),
   .irq                 (irq)
);

/* File: count_source_model.sv */
`timescale 1ns/1ps
module count_source_model (
   // Clock
   input wire logic clk,
   // Pins
   output logic     external_count_input,
   output logic     oscillator_out_pin,
   output logic     gate_input_n
);
   initial begin
      external_count_input = 1'b0;
      oscillator_out_pin = 1'b0;
      gate_input_n = 1'b1;
   end
   // Slow pulses so each level outlasts the pin synchroniser
   task automatic pulses(input int n, input bit osc);
      repeat (n) begin
         repeat (3) @(posedge clk);
         if (osc) oscillator_out_pin <= 1'b1;
         else external_count_input <= 1'b1;
         repeat (3) @(posedge clk);
         if (osc) oscillator_out_pin <= 1'b0;
         else external_count_input <= 1'b0;
      end
      repeat (5) @(posedge clk);
   endtask : pulses
   // The gate pin is driven only from here, so it keeps a single driver
   task automatic set_gate(input bit v);
      gate_input_n <= v;
   endtask : set_gate
endmodule : count_source_model

/* File: tb_gated_sixteen_bit_timer.sv */
`timescale 1ns/1ps
`include "timer_b_map.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_fail++; \
   $display("unexpected %s exp %h got %h", nm, ex, got); end end
module tb_gated_sixteen_bit_timer;
   localparam logic [11:0] A_LOW = `IDX_COUNT_LOW << 2;
   localparam logic [11:0] A_HIGH = `IDX_COUNT_HIGH << 2;
   localparam logic [11:0] A_CTL = `IDX_TIMER_CONTROL << 2;
   localparam logic [11:0] A_FLAG = `IDX_IRQ_FLAG << 2;
   localparam logic [11:0] A_IEN = `IDX_IRQ_ENABLE << 2;
   localparam logic [11:0] A_ICTL = `IDX_IRQ_CONTROL << 2;
   logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
   logic        ext_in, osc_pin, gate_n, int_osc, sleep_mode, osc_on, wake, irq, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   int          n_fail, total_checks;
   // Tick every clock keeps the run short
   gated_sixteen_bit_timer #(.INSTR_DIV(1)) dut (
      .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_count_input(ext_in), .oscillator_out_pin(osc_pin), .gate_input_n(gate_n),
      .internal_oscillator(int_osc), .sleep_mode(sleep_mode), .low_power_osc_on(osc_on),
      .wake_request(wake), .irq(irq));
   count_source_model src (.clk(clk), .external_count_input(ext_in),
      .oscillator_out_pin(osc_pin), .gate_input_n(gate_n));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic apb(input bit is_wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= is_wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Wait states are left to the slave; only the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] ex);
      apb(1'b0, a, 32'h0);
      `CHK($sformatf("reg %h", a), {24'h0, ex}, r)
   endtask : rd
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      #400us;
      n_fail++;
      end_sim();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata, int_osc, sleep_mode} = '0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      rd(A_CTL, 8'h00);
      rd(A_LOW, 8'h00);
      wr(A_CTL, 8'hff);
      rd(A_CTL, 8'h7f);
      `CHK("osc_on", 1'b0, osc_on)
      int_osc <= 1'b1;
      @(posedge clk);
      `CHK("osc_on", 1'b1, osc_on)
      int_osc <= 1'b0;
      wr(A_CTL, 8'h00);
      apb(1'b1, 12'h100, 32'hff);
      `CHK("unmapped err", 1'b1, e)
      apb(1'b0, 12'h041, 32'h0);
      `CHK("misaligned err", 1'b1, e)
      wr(A_LOW, 8'ha5);
      wr(A_HIGH, 8'h5a);
      rd(A_LOW, 8'ha5);
      rd(A_HIGH, 8'h5a);
      $display("registers done");
      for (int s = 0; s < 4; s++) begin
         wr(A_LOW, 8'h00);
         wr(A_HIGH, 8'h00);
         wr(A_CTL, 8'(s << 4) | 8'h01);
         repeat (64) @(posedge clk);
         wr(A_CTL, 8'h00);
         apb(1'b0, A_LOW, 32'h0);
         `CHK("timer rate", 1'b1, (r + 2 >= (66 >> s)) && (r <= (66 >> s) + 2))
      end
      $display("timer done");
      wr(A_LOW, 8'h00);
      wr(A_CTL, 8'h41);
      repeat (20) @(posedge clk);
      src.set_gate(1'b0);
      wr(A_CTL, 8'h40);
      repeat (20) @(posedge clk);
      rd(A_LOW, 8'h00);
      wr(A_CTL, 8'h41);
      repeat (20) @(posedge clk);
      wr(A_CTL, 8'h40);
      apb(1'b0, A_LOW, 32'h0);
      `CHK("gated run", 1'b1, r > 15 && r < 26)
      src.set_gate(1'b1);
      $display("gate done");
      wr(A_LOW, 8'h00);
      wr(A_CTL, 8'h07);
      src.pulses(4, 1'b0);
      rd(A_LOW, 8'h03);
      for (int y = 0; y < 2; y++) begin
         for (int s = 0; s < 4; s++) begin
            wr(A_LOW, 8'h00);
            wr(A_CTL, 8'(s << 4) | 8'(y << 2) | 8'h03);
            src.pulses(16, 1'b0);
            rd(A_LOW, 8'(16 >> s));
         end
      end
      src.pulses(3, 1'b0);
      wr(A_LOW, 8'h00);
      src.pulses(5, 1'b0);
      rd(A_LOW, 8'h00);
      $display("counter done");
      sleep_mode <= 1'b1;
      // Clears the prescaler count left over from the 1:8 runs
      wr(A_LOW, 8'h00);
      wr(A_CTL, 8'h03);
      src.pulses(4, 1'b0);
      rd(A_LOW, 8'h00);
      wr(A_CTL, 8'h07);
      src.pulses(4, 1'b0);
      rd(A_LOW, 8'h04);
      sleep_mode <= 1'b0;
      int_osc <= 1'b1;
      wr(A_CTL, 8'h0f);
      wr(A_LOW, 8'h00);
      src.pulses(4, 1'b0);
      rd(A_LOW, 8'h00);
      src.pulses(4, 1'b1);
      rd(A_LOW, 8'h04);
      int_osc <= 1'b0;
      src.pulses(4, 1'b0);
      rd(A_LOW, 8'h08);
      $display("sleep and oscillator done");
      wr(A_CTL, 8'h07);
      wr(A_LOW, 8'hff);
      wr(A_HIGH, 8'hff);
      rd(A_FLAG, 8'h00);
      wr(A_IEN, 8'h01);
      wr(A_ICTL, 8'h40);
      `CHK("wake early", 1'b0, wake)
      src.pulses(1, 1'b0);
      rd(A_LOW, 8'h00);
      rd(A_HIGH, 8'h00);
      `CHK("wake", 1'b1, wake)
      `CHK("irq masked", 1'b0, irq)
      wr(A_ICTL, 8'hc0);
      `CHK("irq", 1'b1, irq)
      rd(A_FLAG, 8'h01);
      `CHK("irq cleared", 1'b0, irq)
      $display("overflow done");
      end_sim();
   end
endmodule : tb_gated_sixteen_bit_timer
